/* tcc_pkg.sv */
// constants for the 16-bit timer capture and compare block
// assumes an 8-bit register port and a counter outside the block
package tcc_pkg;
   // register offsets (byte index on the 8-bit port)
   localparam logic [3:0] TCC_TIMER_CTRL_B = 4'h0;
   localparam logic [3:0] TCC_COMP_CTRL = 4'h1;
   localparam logic [3:0] TCC_OUT_MODE = 4'h2;
   localparam logic [3:0] TCC_FORCE = 4'h3;
   localparam logic [3:0] TCC_FLAGS = 4'h4;
   localparam logic [3:0] TCC_IRQ_EN = 4'h5;
   localparam logic [3:0] TCC_CAP_LOW = 4'h6;
   localparam logic [3:0] TCC_CAP_HIGH = 4'h7;
   localparam logic [3:0] TCC_CMPA_LOW = 4'h8;
   localparam logic [3:0] TCC_CMPA_HIGH = 4'h9;
   localparam logic [3:0] TCC_CMPB_LOW = 4'hA;
   localparam logic [3:0] TCC_CMPB_HIGH = 4'hB;
   // field positions
   localparam int TCC_FLT_EN_BIT = 0;
   localparam int TCC_EDGE_BIT = 1;
   localparam int TCC_WGM_LSB = 2;
   localparam int TCC_CMP_SEL_BIT = 0;
   localparam int TCC_CAP_FLAG_BIT = 0;
   localparam int TCC_CMP_FLAG_LSB = 1;
   // reset values
   localparam logic [7:0] TCC_CTRL_RST = 8'h00;
   localparam logic [15:0] TCC_REG16_RST = 16'h0000;
   localparam logic [7:0] TCC_UNMAPPED = 8'h00;
   // filter depth in system clock samples
   localparam int TCC_FLT_SAMPLES = 4;
   // fixed top values
   localparam logic [15:0] TCC_TOP_8 = 16'h00FF;
   localparam logic [15:0] TCC_TOP_9 = 16'h01FF;
   localparam logic [15:0] TCC_TOP_10 = 16'h03FF;
   localparam logic [15:0] TCC_TOP_MAX = 16'hFFFF;
   // compare output actions
   localparam logic [1:0] TCC_COM_NONE = 2'h0;
   localparam logic [1:0] TCC_COM_TOGGLE = 2'h1;
   localparam logic [1:0] TCC_COM_CLEAR = 2'h2;
   localparam logic [1:0] TCC_COM_SET = 2'h3;
   // waveform mode classes
   typedef enum logic [1:0] {
      TCC_KIND_PLAIN = 2'b00,
      TCC_KIND_FAST = 2'b01,
      TCC_KIND_DUAL = 2'b10
   } tcc_kind_t;
endpackage : tcc_pkg

/* tcc_capture_compare.sv */
// capture unit with noise filter and two compare channels
// assumes counter, timer tick, top and count_a pulses come from clk logic
//
// The register addresses and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
module tcc_capture_compare
   import tcc_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   // counter side
   input wire logic timer_tick,
   input wire logic [15:0] counter_value,
   input wire logic counter_write,
   input wire logic at_top,
   input wire logic at_count_a,
   input wire logic count_down,
   // trigger pins
   input wire logic capture_pin,
   input wire logic comparator_output,
   // register port
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // interrupt acknowledge and requests
   input wire logic capture_irq_ack,
   input wire logic [1:0] compare_irq_ack,
   output logic capture_irq,
   output logic [1:0] compare_irq,
   // waveform side
   output logic [1:0] compare_output,
   output logic [15:0] top_value
);

   // mode decode helpers
   function automatic logic is_pwm(input logic [3:0] m);
      is_pwm = !(m == 4'h0 || m == 4'h4 || m == 4'hC || m == 4'hD);
   endfunction : is_pwm

   function automatic logic icr_top(input logic [3:0] m);
      icr_top = (m == 4'h8 || m == 4'hA || m == 4'hC || m == 4'hE);
   endfunction : icr_top

   function automatic logic ocra_top(input logic [3:0] m);
      ocra_top = (m == 4'h4 || m == 4'h9 || m == 4'hB || m == 4'hF);
   endfunction : ocra_top

   function automatic tcc_kind_t kind_of(input logic [3:0] m);
      if (!is_pwm(m))
         kind_of = TCC_KIND_PLAIN;
      else if (m == 4'h5 || m == 4'h6 || m == 4'h7 || m >= 4'hE)
         kind_of = TCC_KIND_FAST;
      else
         kind_of = TCC_KIND_DUAL;
   endfunction : kind_of

   function automatic logic apply_com(input logic cur, input logic [1:0] com);
      case (com)
         TCC_COM_TOGGLE: apply_com = ~cur;
         TCC_COM_CLEAR: apply_com = 1'b0;
         TCC_COM_SET: apply_com = 1'b1;
         default: apply_com = cur;
      endcase
   endfunction : apply_com

   // control state
   logic [7:0] timer_ctrl_b;
   logic comparator_capture_select;
   logic [3:0] compare_output_mode;
   logic [2:0] irq_en;
   logic [7:0] hold_byte;
   logic [15:0] capture_register;
   logic [15:0] compare_register [2];
   logic [15:0] compare_buffer [2];
   logic capture_flag;
   logic [1:0] compare_flag;
   logic [1:0] match_pend;
   logic block_arm;
   logic [1:0] pin_sync;
   logic [1:0] cmp_sync;
   logic [TCC_FLT_SAMPLES-1:0] flt_sh;
   logic flt_out;
   logic trig_prev;

   // decoded controls
   logic capture_noise_filter_en;
   logic edge_rising;
   logic [3:0] waveform_mode_sel;
   logic pwm;
   tcc_kind_t kind;
   logic sel_level;
   logic cap_trig;
   logic wr_ok;
   logic [1:0] force_compare_strobe;
   logic [1:0] clr_cmp;
   logic buf_load;

   assign capture_noise_filter_en = timer_ctrl_b[TCC_FLT_EN_BIT];
   assign edge_rising = timer_ctrl_b[TCC_EDGE_BIT];
   assign waveform_mode_sel = timer_ctrl_b[TCC_WGM_LSB+3:TCC_WGM_LSB];
   assign pwm = is_pwm(waveform_mode_sel);
   assign kind = kind_of(waveform_mode_sel);
   assign wr_ok = clk_en && reg_wr;

   // trigger source: pin or comparator level, so a port write can capture
   assign sel_level = comparator_capture_select ? cmp_sync[1] : pin_sync[1];

   // edge detector, gated off when capture register sets top
   assign cap_trig = !icr_top(waveform_mode_sel) &&
      (edge_rising ? (flt_out && !trig_prev) : (!flt_out && trig_prev));

   // force strobes only count in non-PWM modes
   assign force_compare_strobe = (wr_ok && reg_addr == TCC_FORCE && !pwm) ?
      reg_wdata[1:0] : 2'b00;

   // software clear of compare flags: write one or interrupt ack
   assign clr_cmp = compare_irq_ack |
      ((wr_ok && reg_addr == TCC_FLAGS) ? reg_wdata[2:1] : 2'b00);

   // buffer transfer at top for fast and phase modes, count_a for freq mode
   assign buf_load = timer_tick && pwm &&
      ((waveform_mode_sel == 4'h8 || waveform_mode_sel == 4'h9) ? at_count_a : at_top);

   // two-flop synchronisers for the pins
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         pin_sync <= 2'b00;
         cmp_sync <= 2'b00;
      end
      else if (clk_en)
      begin
         pin_sync <= {pin_sync[0], capture_pin};
         cmp_sync <= {cmp_sync[0], comparator_output};
      end
   end

   // noise filter on system clock, four agreeing samples
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         flt_sh <= '0;
         flt_out <= 1'b0;
         trig_prev <= 1'b0;
      end
      else if (clk_en)
      begin
         flt_sh <= {flt_sh[TCC_FLT_SAMPLES-2:0], sel_level};
         trig_prev <= flt_out;
         if (!capture_noise_filter_en)
            flt_out <= sel_level;
         else if (&flt_sh || ~|flt_sh)
            flt_out <= flt_sh[TCC_FLT_SAMPLES-1];
      end
   end

   // control registers
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         timer_ctrl_b <= TCC_CTRL_RST;
         comparator_capture_select <= 1'b0;
         compare_output_mode <= 4'h0;
         irq_en <= 3'h0;
      end
      else if (wr_ok)
      begin
         case (reg_addr)
            TCC_TIMER_CTRL_B: timer_ctrl_b <= reg_wdata;
            TCC_COMP_CTRL: comparator_capture_select <= reg_wdata[TCC_CMP_SEL_BIT];
            TCC_OUT_MODE: compare_output_mode <= reg_wdata[3:0];
            TCC_IRQ_EN: irq_en <= reg_wdata[2:0];
            default: ;
         endcase
      end
   end

   // holding byte: high writes, and low capture read
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         hold_byte <= 8'h00;
      else if (clk_en)
      begin
         if (reg_wr && (reg_addr == TCC_CAP_HIGH || reg_addr == TCC_CMPA_HIGH ||
             reg_addr == TCC_CMPB_HIGH))
            hold_byte <= reg_wdata;
         else if (reg_rd && reg_addr == TCC_CAP_LOW)
            hold_byte <= capture_register[15:8];
      end
   end

   // capture register and flag
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         capture_register <= TCC_REG16_RST;
         capture_flag <= 1'b0;
      end
      else if (clk_en)
      begin
         if (cap_trig)
         begin
            capture_register <= counter_value;
            capture_flag <= 1'b1;
         end
         else
         begin
            if (reg_wr && reg_addr == TCC_CAP_LOW && icr_top(waveform_mode_sel))
               capture_register <= {hold_byte, reg_wdata};
            if (capture_irq_ack || (reg_wr && reg_addr == TCC_FLAGS &&
                reg_wdata[TCC_CAP_FLAG_BIT]))
               capture_flag <= 1'b0;
         end
      end
   end

   // compare registers and their buffers
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         for (int i = 0; i < 2; i++)
         begin
            compare_register[i] <= TCC_REG16_RST;
            compare_buffer[i] <= TCC_REG16_RST;
         end
      end
      else if (clk_en)
      begin
         for (int i = 0; i < 2; i++)
         begin
            if (buf_load)
               compare_register[i] <= compare_buffer[i];
            if (reg_wr && reg_addr == (i == 0 ? TCC_CMPA_LOW : TCC_CMPB_LOW))
            begin
               if (pwm)
                  compare_buffer[i] <= {hold_byte, reg_wdata};
               else
                  compare_register[i] <= {hold_byte, reg_wdata};
            end
         end
      end
   end

   // match blocking after counter write, held until a tick
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         block_arm <= 1'b0;
      else if (clk_en)
      begin
         if (counter_write)
            block_arm <= 1'b1;
         else if (timer_tick)
            block_arm <= 1'b0;
      end
   end

   // comparator and compare flags
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         match_pend <= 2'b00;
         compare_flag <= 2'b00;
      end
      else if (clk_en)
      begin
         for (int i = 0; i < 2; i++)
         begin
            if (timer_tick)
               match_pend[i] <= !block_arm &&
                  counter_value == compare_register[i];
            if (timer_tick && match_pend[i])
               compare_flag[i] <= 1'b1;
            else if (clr_cmp[i])
               compare_flag[i] <= 1'b0;
         end
      end
   end

   // compare output state, untouched by mode switches
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         compare_output <= 2'b00;
      else if (clk_en)
      begin
         for (int i = 0; i < 2; i++)
         begin
            case (kind)
               TCC_KIND_PLAIN:
               begin
                  if ((timer_tick && match_pend[i]) || force_compare_strobe[i])
                     compare_output[i] <= apply_com(compare_output[i],
                        compare_output_mode[2*i+:2]);
               end
               TCC_KIND_FAST:
               begin
                  if (timer_tick && match_pend[i] &&
                      compare_output_mode[2*i+1])
                     compare_output[i] <= compare_output_mode[2*i];
                  else if (timer_tick && at_count_a && compare_output_mode[2*i+1])
                     compare_output[i] <= !compare_output_mode[2*i];
               end
               TCC_KIND_DUAL:
               begin
                  if (timer_tick && match_pend[i] &&
                      compare_output_mode[2*i+1])
                     compare_output[i] <= count_down ^ compare_output_mode[2*i];
               end
               default: compare_output[i] <= compare_output[i];
            endcase
         end
      end
   end

   // counter top value for the counter sequencer
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         top_value <= TCC_TOP_MAX;
      else if (clk_en)
      begin
         if (ocra_top(waveform_mode_sel))
            top_value <= compare_register[0];
         else if (icr_top(waveform_mode_sel))
            top_value <= capture_register;
         else
            case (waveform_mode_sel)
               4'h1, 4'h5: top_value <= TCC_TOP_8;
               4'h2, 4'h6: top_value <= TCC_TOP_9;
               4'h3, 4'h7: top_value <= TCC_TOP_10;
               default: top_value <= TCC_TOP_MAX;
            endcase
      end
   end

   // interrupt requests
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         capture_irq <= 1'b0;
         compare_irq <= 2'b00;
      end
      else if (clk_en)
      begin
         capture_irq <= capture_flag && irq_en[0];
         compare_irq <= compare_flag & irq_en[2:1];
      end
   end

   // read data, one cycle after the strobe
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         reg_rdata <= 8'h00;
      else if (clk_en)
      begin
         if (!reg_rd)
            reg_rdata <= 8'h00;
         else
            case (reg_addr)
               TCC_TIMER_CTRL_B: reg_rdata <= timer_ctrl_b;
               TCC_COMP_CTRL: reg_rdata <= {7'h00, comparator_capture_select};
               TCC_OUT_MODE: reg_rdata <= {4'h0, compare_output_mode};
               TCC_FLAGS: reg_rdata <= {5'h00, compare_flag, capture_flag};
               TCC_IRQ_EN: reg_rdata <= {5'h00, irq_en};
               TCC_CAP_LOW: reg_rdata <= capture_register[7:0];
               TCC_CAP_HIGH: reg_rdata <= hold_byte;
               TCC_CMPA_LOW: reg_rdata <= pwm ? compare_buffer[0][7:0] :
                  compare_register[0][7:0];
               TCC_CMPA_HIGH: reg_rdata <= pwm ? compare_buffer[0][15:8] :
                  compare_register[0][15:8];
               TCC_CMPB_LOW: reg_rdata <= pwm ? compare_buffer[1][7:0] :
                  compare_register[1][7:0];
               TCC_CMPB_HIGH: reg_rdata <= pwm ? compare_buffer[1][15:8] :
                  compare_register[1][15:8];
               default: reg_rdata <= TCC_UNMAPPED;
            endcase
      end
   end

   // checks
   AST_CAPTURE_STAMP: assert property (@(posedge clk) disable iff (sys_rst)
      clk_en && cap_trig |=> capture_flag && capture_register == $past(counter_value))
      else $error("capture did not stamp counter and flag");
   AST_TRIG_OFF: assert property (@(posedge clk) disable iff (sys_rst)
      clk_en && icr_top(waveform_mode_sel) && !capture_flag |=> !capture_flag)
      else $error("capture while capture register sets top");
   AST_FILTER_AGREE: assert property (@(posedge clk) disable iff (sys_rst)
      clk_en && capture_noise_filter_en && flt_out != flt_sh[3] |=>
      $past(&flt_sh || ~|flt_sh) || flt_out == $past(flt_out))
      else $error("filter moved without four equal samples");
   AST_MATCH_SEEN: assert property (@(posedge clk) disable iff (sys_rst)
      clk_en && timer_tick && counter_value == compare_register[0] && !block_arm
      |=> match_pend[0])
      else $error("unblocked equality not noted as a match");
   AST_FLAG_NEXT_TICK: assert property (@(posedge clk) disable iff (sys_rst)
      clk_en && timer_tick && match_pend[0] |=> compare_flag[0])
      else $error("match did not set flag at next tick");
   AST_BLOCK: assert property (@(posedge clk) disable iff (sys_rst)
      clk_en && timer_tick && block_arm |=> match_pend == 2'b00)
      else $error("match not blocked after counter write");
   AST_FORCE_NO_FLAG: assert property (@(posedge clk) disable iff (sys_rst)
      force_compare_strobe[0] && !compare_flag[0] && !(timer_tick && match_pend[0])
      |=> !compare_flag[0])
      else $error("force strobe set the flag");
   AST_MODE_ZERO: assert property (@(posedge clk) disable iff (sys_rst)
      compare_output_mode[1:0] == TCC_COM_NONE |=> $stable(compare_output[0]))
      else $error("output moved with output mode zero");
   AST_DIRECT_WRITE: assert property (@(posedge clk) disable iff (sys_rst)
      wr_ok && reg_addr == TCC_CMPA_LOW && !pwm |=>
      compare_register[0] == {$past(hold_byte), $past(reg_wdata)})
      else $error("non-PWM low write did not commit");
   AST_IRQ: assert property (@(posedge clk) disable iff (sys_rst)
      clk_en && compare_flag[1] && irq_en[2] |=> compare_irq[1])
      else $error("enabled flag raised no interrupt");

endmodule : tcc_capture_compare

/* tcc_event_src.sv */
// far-side model: capture pin and comparator output levels
// assumes the bench calls its tasks just after a rising clock edge
`timescale 1ns/1ps
module tcc_event_src
(
   // clock
   input wire logic clk,
   // event levels toward the block
   output logic capture_pin,
   output logic comparator_output
);
   // requested levels, both idle low
   logic pin_lvl = 1'b0;
   logic cmp_lvl = 1'b0;
   // lines move on a clock edge, like a source outside the block
   always @(posedge clk)
   begin
      capture_pin <= pin_lvl;
      comparator_output <= cmp_lvl;
   end
   // pin level, also how software forces a capture
   task automatic set_pin(input logic v);
      pin_lvl <= v;
   endtask : set_pin
   // comparator level, used once the source is switched
   task automatic set_cmp(input logic v);
      cmp_lvl <= v;
   endtask : set_cmp
endmodule : tcc_event_src

/* tcc_capture_compare_tb_top.sv */
// self-checking bench for the capture and compare block
// assumes a free counter is mimicked by the bench through counter_value
`timescale 1ns/1ps
module tcc_capture_compare_tb_top;
   import tcc_pkg::*;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic clk_en = 1'b1;
   logic at_top = 1'b0;
   logic at_count_a = 1'b0;
   logic count_down = 1'b0;
   logic timer_tick = 1'b0;
   logic [15:0] counter_value = 16'h0000;
   logic counter_write = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic capture_irq_ack = 1'b0;
   logic [1:0] compare_irq_ack = 2'h0;
   logic [7:0] reg_rdata;
   logic capture_irq;
   logic [1:0] compare_irq;
   logic [1:0] compare_output;
   logic [15:0] top_value;
   wire logic capture_pin;
   wire logic comparator_output;
   logic rd_q = 1'b0;
   logic [7:0] exp_q[$];
   int err_count = 0;
   int samples_checked = 0;
   int seed = 43038;
   logic [15:0] v1, v2, v3, v4, x;
   // clock, 50 ns period
   always #25 clk = ~clk;
   tcc_event_src u_src (.clk(clk), .capture_pin(capture_pin),
      .comparator_output(comparator_output));
   tcc_capture_compare u_dut (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
      .timer_tick(timer_tick), .counter_value(counter_value),
      .counter_write(counter_write), .at_top(at_top), .at_count_a(at_count_a),
      .count_down(count_down), .capture_pin(capture_pin),
      .comparator_output(comparator_output), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .capture_irq_ack(capture_irq_ack),
      .compare_irq_ack(compare_irq_ack), .capture_irq(capture_irq),
      .compare_irq(compare_irq), .compare_output(compare_output),
      .top_value(top_value));
   // compare seen against expected
   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         err_count++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   // verdict and end of run
   task automatic end_of_test;
      $display("checked %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : end_of_test
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      @(posedge clk);
   endtask : wr
   // read: note expected byte, monitor compares it
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(posedge clk);
   endtask : rd
   // one timer tick at a given counter value
   task automatic tick(input logic [15:0] v);
      counter_value <= v;
      timer_tick <= 1'b1;
      @(posedge clk);
      timer_tick <= 1'b0;
      @(posedge clk);
   endtask : tick
   task automatic done(input string name);
      $display("test %s done", name);
   endtask : done
   // read data monitor, one cycle after the strobe
   always @(posedge clk)
   begin
      rd_q <= reg_rd;
      if (rd_q)
         chk("reg_rdata", {8'h00, reg_rdata}, {8'h00, exp_q.pop_front()});
   end
   // watchdog
   initial
   begin
      #200000;
      err_count++;
      end_of_test();
   end
   // main sequence
   initial
   begin
      v1 = 16'($random(seed));
      v2 = 16'($random(seed));
      v3 = 16'($random(seed));
      v4 = 16'($random(seed));
      x = (16'($random(seed)) & 16'h7FFF) | 16'h0100;
      cyc(3);
      sys_rst <= 1'b0;
      @(posedge clk);
      chk("top_value", top_value, TCC_TOP_MAX);
      chk("compare_output", {14'h0, compare_output}, 16'h0000);
      rd(TCC_TIMER_CTRL_B, TCC_CTRL_RST);
      rd(TCC_CMPA_LOW, 8'h00);
      rd(4'hC, TCC_UNMAPPED);
      done("reset");
      // capture on rising pin edge, no filter
      wr(TCC_IRQ_EN, 8'h01);
      wr(TCC_TIMER_CTRL_B, 8'h02);
      counter_value <= v1;
      u_src.set_pin(1'b1);
      cyc(12);
      chk("capture_irq", {15'h0, capture_irq}, 16'h0001);
      rd(TCC_FLAGS, 8'h01);
      rd(TCC_CAP_LOW, v1[7:0]);
      rd(TCC_CAP_HIGH, v1[15:8]);
      // falling edge ignored, next rise overwrites
      counter_value <= v2;
      u_src.set_pin(1'b0);
      cyc(12);
      rd(TCC_CAP_LOW, v1[7:0]);
      u_src.set_pin(1'b1);
      cyc(12);
      rd(TCC_CAP_LOW, v2[7:0]);
      rd(TCC_CAP_HIGH, v2[15:8]);
      wr(TCC_TIMER_CTRL_B, 8'h00);
      wr(TCC_FLAGS, 8'h01);
      counter_value <= v3;
      u_src.set_pin(1'b0);
      cyc(12);
      rd(TCC_CAP_LOW, v3[7:0]);
      capture_irq_ack <= 1'b1;
      @(posedge clk);
      capture_irq_ack <= 1'b0;
      cyc(2);
      chk("capture_irq", {15'h0, capture_irq}, 16'h0000);
      rd(TCC_FLAGS, 8'h00);
      done("capture");
      // filter: short glitch rejected, held level delayed
      wr(TCC_TIMER_CTRL_B, 8'h03);
      counter_value <= v4;
      u_src.set_pin(1'b1);
      cyc(2);
      u_src.set_pin(1'b0);
      cyc(12);
      rd(TCC_FLAGS, 8'h00);
      u_src.set_pin(1'b1);
      cyc(5);
      chk("capture_irq", {15'h0, capture_irq}, 16'h0000);
      cyc(11);
      chk("capture_irq", {15'h0, capture_irq}, 16'h0001);
      rd(TCC_CAP_LOW, v4[7:0]);
      done("filter");
      // comparator as source, pin then ignored
      wr(TCC_TIMER_CTRL_B, 8'h02);
      wr(TCC_COMP_CTRL, 8'h01);
      wr(TCC_FLAGS, 8'h07);
      counter_value <= v1;
      u_src.set_pin(1'b0);
      cyc(4);
      u_src.set_pin(1'b1);
      cyc(12);
      rd(TCC_FLAGS, 8'h00);
      u_src.set_cmp(1'b1);
      cyc(12);
      rd(TCC_FLAGS, 8'h01);
      rd(TCC_CAP_LOW, v1[7:0]);
      done("source");
      // compare write order, match flag, irq, blocking
      wr(TCC_FLAGS, 8'h07);
      wr(TCC_IRQ_EN, 8'h02);
      wr(TCC_CMPA_HIGH, x[15:8]);
      wr(TCC_CMPA_LOW, x[7:0]);
      rd(TCC_CMPA_LOW, x[7:0]);
      wr(TCC_CMPA_HIGH, ~x[15:8]);
      rd(TCC_CMPA_HIGH, x[15:8]);
      wr(TCC_CMPA_HIGH, x[15:8]);
      tick(x);
      rd(TCC_FLAGS, 8'h00);
      tick(x + 16'h0001);
      cyc(2);
      chk("compare_irq", {14'h0, compare_irq}, 16'h0001);
      rd(TCC_FLAGS, 8'h02);
      compare_irq_ack <= 2'h1;
      @(posedge clk);
      compare_irq_ack <= 2'h0;
      cyc(2);
      chk("compare_irq", {14'h0, compare_irq}, 16'h0000);
      counter_write <= 1'b1;
      @(posedge clk);
      counter_write <= 1'b0;
      tick(x);
      tick(x + 16'h0001);
      rd(TCC_FLAGS, 8'h00);
      done("compare");
      // force strobe and output modes
      wr(TCC_OUT_MODE, {6'h00, TCC_COM_TOGGLE});
      wr(TCC_FORCE, 8'h01);
      chk("compare_output", {14'h0, compare_output}, 16'h0001);
      rd(TCC_FLAGS, 8'h00);
      wr(TCC_OUT_MODE, {6'h00, TCC_COM_NONE});
      wr(TCC_FORCE, 8'h01);
      chk("compare_output", {14'h0, compare_output}, 16'h0001);
      wr(TCC_OUT_MODE, {6'h00, TCC_COM_CLEAR});
      wr(TCC_FORCE, 8'h01);
      chk("compare_output", {14'h0, compare_output}, 16'h0000);
      wr(TCC_OUT_MODE, {6'h00, TCC_COM_SET});
      wr(TCC_FORCE, 8'h01);
      wr(TCC_TIMER_CTRL_B, 8'h06);
      cyc(2);
      chk("compare_output", {14'h0, compare_output}, 16'h0001);
      chk("top_value", top_value, TCC_TOP_8);
      done("force");
      // fast pwm: compare loads at top, clear at match, set at count_a
      wr(TCC_OUT_MODE, {6'h00, TCC_COM_CLEAR});
      wr(TCC_TIMER_CTRL_B, 8'h14);
      wr(TCC_CMPA_HIGH, 8'h00);
      wr(TCC_CMPA_LOW, 8'h40);
      rd(TCC_CMPA_LOW, 8'h40);
      tick(16'h0040);
      at_top <= 1'b1;
      tick(16'h00FF);
      at_top <= 1'b0;
      chk("compare_output", {14'h0, compare_output}, 16'h0001);
      tick(16'h0040);
      tick(16'h0041);
      chk("compare_output", {14'h0, compare_output}, 16'h0000);
      at_count_a <= 1'b1;
      tick(16'h0000);
      at_count_a <= 1'b0;
      chk("compare_output", {14'h0, compare_output}, 16'h0001);
      // dual slope: direction picks the level at a match
      wr(TCC_TIMER_CTRL_B, 8'h04);
      tick(16'h0040);
      tick(16'h0041);
      chk("compare_output", {14'h0, compare_output}, 16'h0000);
      count_down <= 1'b1;
      tick(16'h0040);
      tick(16'h003F);
      count_down <= 1'b0;
      chk("compare_output", {14'h0, compare_output}, 16'h0001);
      // channel A as top, then capture register as top with trigger off
      wr(TCC_TIMER_CTRL_B, 8'h10);
      cyc(1);
      chk("top_value", top_value, 16'h0040);
      wr(TCC_FLAGS, 8'h07);
      wr(TCC_TIMER_CTRL_B, 8'h30);
      u_src.set_cmp(1'b0);
      cyc(8);
      rd(TCC_FLAGS, 8'h00);
      wr(TCC_CAP_HIGH, 8'h12);
      wr(TCC_CAP_LOW, 8'h34);
      cyc(1);
      chk("top_value", top_value, 16'h1234);
      // low clock enable ignores a write
      clk_en <= 1'b0;
      wr(TCC_IRQ_EN, 8'h05);
      clk_en <= 1'b1;
      rd(TCC_IRQ_EN, 8'h02);
      done("pwm");
      end_of_test();
   end
endmodule : tcc_capture_compare_tb_top
